// ===== tgcr_pkg.sv
// tgcr_pkg: register map, field layout, reset values and carrier types of the gain regs
package tgcr_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] TGCR_IDX_P3_START = 10'h0_b3; // profile-3 start gain time
  localparam logic [9:0] TGCR_IDX_P3_HOLD = 10'h0_b4;  // profile-3 hold gain time
  localparam logic [9:0] TGCR_IDX_MODE_CTRL = 10'h0_b5; // gain_mode_control
  localparam logic [9:0] TGCR_IDX_GAIN_CFG = 10'h0_b6;  // gain_configuration
  localparam logic [9:0] TGCR_IDX_WAIT = 10'h0_b7;      // internal start period
  localparam logic [9:0] TGCR_IDX_STATUS = 10'h0_c0;    // live block state, read only

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TGCR_RST_P3_START = 16'h0000;
  localparam logic [15:0] TGCR_RST_P3_HOLD = 16'h0000;
  localparam logic [15:0] TGCR_RST_MODE_CTRL = 16'h0000;
  localparam logic [15:0] TGCR_RST_GAIN_CFG = 16'h0000;
  localparam logic [15:0] TGCR_RST_WAIT = 16'h0000;

  // ----------------------------------------------------------------
  // field positions and write masks
  // ----------------------------------------------------------------
  localparam int TGCR_POS_MANUAL_START = 10;        // self-clearing one-shot request
  localparam int TGCR_POS_MODE_LO = 14;             // gain mode field, bits 15:14
  localparam int TGCR_POS_SLOPE_HI_LO = 2;          // slope factor bits 3:1 at 4:2
  localparam logic [15:0] TGCR_CTRL_WMASK = 16'hf1ff; // bits 11,10,9 never stored
  localparam logic [15:0] TGCR_CFG_WMASK = 16'hfffc;  // bits 1:0 never stored

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] TGCR_RESP_OKAY = 2'h0;
  localparam logic [1:0] TGCR_RESP_SLVERR = 2'h2;

  // gain mode encodings
  typedef enum logic [1:0] {
    TGCR_MODE_EXT_NONUNI = 2'h0,
    TGCR_MODE_RAMP = 2'h1,
    TGCR_MODE_FIXED = 2'h2,
    TGCR_MODE_INT_NONUNI = 2'h3
  } tgcr_mode_type;

  // gain_mode_control layout
  typedef struct packed {
    logic slope_lsb;          // curve_slope_factor bit 0
    logic int_start_en;       // 1: periodic internal start
    logic [1:0] mem_bank;     // memory bank select
    logic rsv11;              // held at zero
    logic manual_start;       // reads zero, acts on write
    logic rsv9;               // held at zero
    logic [8:0] fixed_gain_code;
  } tgcr_mode_ctrl_type;

  // gain_configuration layout
  typedef struct packed {
    tgcr_mode_type mode;
    logic [1:0] profile_reg_sel;
    logic profile_pin_disable;
    logic [3:0] input_resistance_select;
    logic attenuator_order;
    logic attenuator_disable;
    logic [2:0] slope_hi;
    logic [1:0] rsv;          // held at zero
  } tgcr_gain_cfg_type;

  // settings handed to the gain curve logic
  typedef struct packed {
    tgcr_mode_type mode;
    logic [1:0] active_profile;
    logic [1:0] mem_bank;
    logic [3:0] curve_slope_factor;
    logic attenuator_order;
    logic attenuator_disable;
    logic [3:0] input_resistance_select;
    logic [8:0] gain_code;
    logic gain_code_valid;
    logic [15:0] p3_start_time;
    logic [15:0] p3_hold_time;
  } tgcr_settings_type;

endpackage

// ===== tgcr_gain_regs.sv
// tgcr_gain_regs: gain control register bank with AXI4-Lite slave and start-pulse logic
`timescale 1ns/1ns

// What this block does
// - mode field picks one of four gain modes
// - pins or register field choose active profile
// - profile field code maps to profile 0..3
// - start source is external or internal periodic
// - fixed gain mode applies the fixed code
// - bank field selects internal memory bank
// - slope factor joins two registers' bits
// - order bit swaps attenuator and amplifier stepping
// - disable bit switches the attenuator off
// - profile-3 start gain time held here
// - profile-3 hold gain time held here
// - wait field sets internal start period
module tgcr_gain_regs
  import tgcr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // device pins
  input wire logic [1:0] profile_select_pins_in,
  input wire logic ext_start_in,
  // to the gain curve logic
  output tgcr_settings_type settings_out,
  output logic gain_start_out
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // byte-lane merge of a 16-bit register; upper lanes have no storage
  function automatic logic [15:0] wmerge(input logic [15:0] old_val,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [15:0] res;
    res = old_val;
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    return res;
  endfunction

  // word index of an address, or all ones when above the decoded window
  function automatic logic [9:0] addr_index(input logic [31:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    if (addr[31:12] != 20'h0_0000) begin
      idx = 10'h3_ff;
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] p3_start_q;            // profile-3 start gain time
  logic [15:0] p3_hold_q;             // profile-3 hold gain time
  tgcr_mode_ctrl_type ctrl_q;         // gain_mode_control
  tgcr_gain_cfg_type cfg_q;           // gain_configuration
  logic [15:0] wait_q;                // internal start period in clocks minus one

  // ----------------------------------------------------------------
  // bus write channel
  // ----------------------------------------------------------------
  logic aw_held_q;                    // address captured, waiting for data
  logic w_held_q;                     // data captured, waiting for address
  logic [9:0] wr_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;                      // the cycle the register file is written

  // address and data are taken in either order, one write in flight
  assign s_axi_awready_out = !aw_held_q && !bvalid_q;
  assign s_axi_wready_out = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

  // capture address
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aw_held_q <= 1'b0;
      wr_idx_q <= 10'h0_00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_q <= 1'b1;
      wr_idx_q <= addr_index(s_axi_awaddr_in);
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  // capture data and strobes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata_in;
      wstrb_q <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // write response; unmapped targets answer slverr and change nothing
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= TGCR_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      unique case (wr_idx_q)
        TGCR_IDX_P3_START, TGCR_IDX_P3_HOLD, TGCR_IDX_MODE_CTRL,
        TGCR_IDX_GAIN_CFG, TGCR_IDX_WAIT, TGCR_IDX_STATUS: begin
          bresp_q <= TGCR_RESP_OKAY;
        end
        default: begin
          bresp_q <= TGCR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // response stands until the master takes it
  bresp_stands_a: assert property (@(posedge clk_in) disable iff (reset_in)
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before bready");

  // ----------------------------------------------------------------
  // register file writes
  // ----------------------------------------------------------------

  // profile-3 times and start period, plain read/write words
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      p3_start_q <= TGCR_RST_P3_START;
      p3_hold_q <= TGCR_RST_P3_HOLD;
      wait_q <= TGCR_RST_WAIT;
    end else if (wr_fire) begin
      if (wr_idx_q == TGCR_IDX_P3_START) begin
        p3_start_q <= wmerge(p3_start_q, wdata_q, wstrb_q);
      end
      if (wr_idx_q == TGCR_IDX_P3_HOLD) begin
        p3_hold_q <= wmerge(p3_hold_q, wdata_q, wstrb_q);
      end
      if (wr_idx_q == TGCR_IDX_WAIT) begin
        wait_q <= wmerge(wait_q, wdata_q, wstrb_q);
      end
    end
  end

  // control words; reserved and one-shot bits are masked so they never store
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= tgcr_mode_ctrl_type'(TGCR_RST_MODE_CTRL);
      cfg_q <= tgcr_gain_cfg_type'(TGCR_RST_GAIN_CFG);
    end else if (wr_fire) begin
      if (wr_idx_q == TGCR_IDX_MODE_CTRL) begin
        ctrl_q <= tgcr_mode_ctrl_type'(wmerge(ctrl_q, wdata_q, wstrb_q) & TGCR_CTRL_WMASK);
      end
      if (wr_idx_q == TGCR_IDX_GAIN_CFG) begin
        cfg_q <= tgcr_gain_cfg_type'(wmerge(cfg_q, wdata_q, wstrb_q) & TGCR_CFG_WMASK);
      end
    end
  end

  reserved_zero_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !ctrl_q.rsv11 && !ctrl_q.rsv9 && !ctrl_q.manual_start && cfg_q.rsv == 2'h0)
    else $error("reserved control bit became nonzero");

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pins_meta_q;            // first stage, read only by second stage
  logic [1:0] pins_sync_q;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;                   // for rising-edge detection
  logic ext_edge;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pins_meta_q <= 2'h0;
      pins_sync_q <= 2'h0;
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      pins_meta_q <= profile_select_pins_in;
      pins_sync_q <= pins_meta_q;
      ext_meta_q <= ext_start_in;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  assign ext_edge = ext_sync_q && !ext_prev_q;

  // ----------------------------------------------------------------
  // start generation
  // ----------------------------------------------------------------
  logic [15:0] period_cnt_q;          // clocks since the last internal start
  logic periodic_fire;
  logic manual_pend_q;                // one-shot request from software
  logic start_q;

  assign periodic_fire = ctrl_q.int_start_en && (period_cnt_q == wait_q);

  // free period counter, held at zero while the internal source is off
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      period_cnt_q <= 16'h0000;
    end else if (!ctrl_q.int_start_en || periodic_fire) begin
      period_cnt_q <= 16'h0000;
    end else begin
      period_cnt_q <= period_cnt_q + 16'h0001;
    end
  end

  // a write of one to the manual start bit arms exactly one pulse
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      manual_pend_q <= 1'b0;
    end else begin
      manual_pend_q <= wr_fire && (wr_idx_q == TGCR_IDX_MODE_CTRL) && wstrb_q[1]
                       && wdata_q[TGCR_POS_MANUAL_START];
    end
  end

  // external edges are ignored while the device makes its own starts
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      start_q <= 1'b0;
    end else begin
      start_q <= (ctrl_q.int_start_en ? periodic_fire : ext_edge) || manual_pend_q;
    end
  end

  assign gain_start_out = start_q;

  manual_pulse_a: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_fire && wr_idx_q == TGCR_IDX_MODE_CTRL && wstrb_q[1] && wdata_q[10]
    |-> ##2 gain_start_out)
    else $error("manual start write gave no start pulse");

  ext_source_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !ctrl_q.int_start_en && !ext_edge && !manual_pend_q |=> !gain_start_out)
    else $error("start pulse without a cause in external mode");

  period_wrap_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ctrl_q.int_start_en && period_cnt_q == wait_q |=> gain_start_out && period_cnt_q == 0)
    else $error("internal start period not honoured");

  // ----------------------------------------------------------------
  // settings to the gain curve logic
  // ----------------------------------------------------------------
  tgcr_settings_type set_q;

  // all fields come from flops; the profile follows pins or register field
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      set_q <= '0;
    end else begin
      set_q.mode <= cfg_q.mode;
      set_q.active_profile <= cfg_q.profile_pin_disable ? cfg_q.profile_reg_sel
                                                        : pins_sync_q;
      set_q.mem_bank <= ctrl_q.mem_bank;
      set_q.curve_slope_factor <= {cfg_q.slope_hi, ctrl_q.slope_lsb};
      set_q.attenuator_order <= cfg_q.attenuator_order;
      set_q.attenuator_disable <= cfg_q.attenuator_disable;
      set_q.input_resistance_select <= cfg_q.input_resistance_select;
      set_q.gain_code <= ctrl_q.fixed_gain_code;
      set_q.gain_code_valid <= (cfg_q.mode == TGCR_MODE_FIXED);
      set_q.p3_start_time <= p3_start_q;
      set_q.p3_hold_time <= p3_hold_q;
    end
  end

  assign settings_out = set_q;

  mode_follow_a: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_fire && wr_idx_q == TGCR_IDX_GAIN_CFG && wstrb_q[1]
    |-> ##2 settings_out.mode == $past(wdata_q[15:14], 2))
    else $error("gain mode output does not follow its field");

  profile_reg_a: assert property (@(posedge clk_in) disable iff (reset_in)
    cfg_q.profile_pin_disable |=> settings_out.active_profile == $past(cfg_q.profile_reg_sel))
    else $error("profile not taken from register field");

  profile_pin_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !cfg_q.profile_pin_disable |=> settings_out.active_profile == $past(pins_sync_q))
    else $error("profile not taken from pins");

  fixed_code_a: assert property (@(posedge clk_in) disable iff (reset_in)
    cfg_q.mode == TGCR_MODE_FIXED
    |=> settings_out.gain_code_valid
        && settings_out.gain_code == $past(ctrl_q.fixed_gain_code))
    else $error("fixed gain code not applied");

  slope_join_a: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_fire && wr_idx_q == TGCR_IDX_GAIN_CFG && wstrb_q[0]
    |-> ##2 settings_out.curve_slope_factor[3:1] == $past(wdata_q[4:2], 2))
    else $error("slope factor upper bits wrong");

  // ----------------------------------------------------------------
  // bus read channel
  // ----------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign s_axi_arready_out = !rvalid_q;

  // one read in flight; answer one cycle after the address is taken
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= TGCR_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_q <= 1'b1;
      rresp_q <= TGCR_RESP_OKAY;
      unique case (addr_index(s_axi_araddr_in))
        TGCR_IDX_P3_START: rdata_q <= {16'h0000, p3_start_q};
        TGCR_IDX_P3_HOLD: rdata_q <= {16'h0000, p3_hold_q};
        TGCR_IDX_MODE_CTRL: rdata_q <= {16'h0000, ctrl_q};
        TGCR_IDX_GAIN_CFG: rdata_q <= {16'h0000, cfg_q};
        TGCR_IDX_WAIT: rdata_q <= {16'h0000, wait_q};
        // live state: synced pins, external start level, effective profile
        TGCR_IDX_STATUS: rdata_q <= {27'h000_0000, set_q.active_profile, ext_sync_q,
                                     pins_sync_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= TGCR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

endmodule

// ===== tb.sv
// tb: self-checking bench for the gain control register bank
`timescale 1ns/1ns
module tb
  import tgcr_pkg::*;
;
  // ----------------------------------------------------------------
  // bench signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0; // 10 MHz bench clock
  logic reset_in = 1'b1; // synchronous, held at start
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, gain_start;
  logic [1:0] bresp, rresp;
  logic [1:0] pins = 2'h0; // profile pins, driven at random
  logic ext_start = 1'b0; // external start pin
  logic [3:0] wstrb = 4'h3; // write byte lanes, both low lanes by default
  tgcr_settings_type settings;
  int fail_count = 0, num_checks = 0;
  int cyc = 0, last_cyc = 0, pmin = 1000, pulses = 0; // start pulse bookkeeping
  logic [31:0] rnd = 32'h0000_c3f9; // lfsr state, fixed seed
  logic [15:0] ctrl, cfg, wt, p0;

  always #50 clk_in = ~clk_in;

  tgcr_gain_regs DUT (
    .clk_in(clk_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .profile_select_pins_in(pins), .ext_start_in(ext_start),
    .settings_out(settings), .gain_start_out(gain_start)
  );

  // pulses sampled mid-cycle, where the output flop has settled
  always @(negedge clk_in) begin
    cyc++;
    if (gain_start === 1'b1) begin
      pulses++;
      if (cyc - last_cyc < pmin) pmin = cyc - last_cyc;
      last_cyc = cyc;
    end
  end

  // ----------------------------------------------------------------
  // expectation functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] addr_of(input logic [9:0] idx);
    return {20'h0_0000, idx, 2'b00};
  endfunction

  // reserved and self-clearing bits read back as zero
  function automatic logic [15:0] exp_read(input logic [9:0] idx, input logic [15:0] d);
    if (idx == TGCR_IDX_MODE_CTRL) return d & TGCR_CTRL_WMASK;
    if (idx == TGCR_IDX_GAIN_CFG) return d & TGCR_CFG_WMASK;
    return d;
  endfunction

  function automatic logic [3:0] exp_slope(input logic [15:0] c, input logic [15:0] g);
    return {g[4:2], c[15]};
  endfunction

  // register field wins only while the pins are disabled
  function automatic logic [1:0] exp_prof(input logic dis, input logic [1:0] sel,
                                          input logic [1:0] p);
    return dis ? sel : p;
  endfunction

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  task automatic step_rnd();
    rnd = lfsr_step(rnd);
  endtask

  // ----------------------------------------------------------------
  // axi4-lite master: handshakes judged mid-cycle, acted on at the edge;
  // each call waits one edge first so back-to-back calls never drive a
  // ready or valid twice in one time step
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [31:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    int n;
    @(posedge clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk_in);
      ah = awvalid && (awready === 1'b1);
      wh = wvalid && (wready === 1'b1);
      bh = (bvalid === 1'b1);
      if (bh) check("bresp", 32'(bresp), 32'(er));
      @(posedge clk_in);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
      n++;
      if (n > 100) begin
        fail_count++;
        complete_run();
      end
    end
  endtask

  task automatic axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, rh;
    int n;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk_in);
      ah = arvalid && (arready === 1'b1);
      rh = (rvalid === 1'b1);
      if (rh) check("rresp", 32'(rresp), 32'(er));
      if (rh) check("rdata", rdata, ed);
      @(posedge clk_in);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
      n++;
      if (n > 100) begin
        fail_count++;
        complete_run();
      end
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    axi_write(addr_of(idx), d, TGCR_RESP_OKAY);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [15:0] d);
    axi_read(addr_of(idx), {16'h0000, exp_read(idx, d)}, TGCR_RESP_OKAY);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    // the five stored registers and the mode setting start at zero
    for (int k = 3; k < 8; k++) rd(10'h0_b0 + 10'(k), 16'h0000);
    check("settings", 32'(settings.mode), 32'h0000_0000);
    // all four modes, register-chosen profile, random field contents
    for (int i = 0; i < 4; i++) begin
      step_rnd();
      // software keeps reserved bits and the one-shot bit at zero here
      ctrl = rnd[15:0] & 16'hb1ff;
      step_rnd();
      cfg = (rnd[15:0] & 16'h07fc) | {2'(i), 2'(i), 1'b1, 11'h000};
      pins <= rnd[17:16];
      wr(TGCR_IDX_MODE_CTRL, ctrl);
      wr(TGCR_IDX_GAIN_CFG, cfg);
      repeat (6) @(posedge clk_in);
      check("mode", 32'(settings.mode), 32'(i));
      check("gvalid", 32'(settings.gain_code_valid), 32'(i == 2));
      if (i == 2) check("gcode", 32'(settings.gain_code), 32'(ctrl[8:0]));
      check("bank", 32'(settings.mem_bank), 32'(ctrl[13:12]));
      check("slope", 32'(settings.curve_slope_factor), 32'(exp_slope(ctrl, cfg)));
      check("order", 32'(settings.attenuator_order), 32'(cfg[6]));
      check("atdis", 32'(settings.attenuator_disable), 32'(cfg[5]));
      check("rsel", 32'(settings.input_resistance_select), 32'(cfg[10:7]));
      check("prof", 32'(settings.active_profile), 32'(exp_prof(1'b1, 2'(i), pins)));
      rd(TGCR_IDX_MODE_CTRL, ctrl);
      rd(TGCR_IDX_GAIN_CFG, cfg);
    end
    // profile taken from the pins once the field is disabled
    wr(TGCR_IDX_GAIN_CFG, 16'h3000);
    for (int i = 0; i < 4; i++) begin
      step_rnd();
      pins <= rnd[1:0];
      repeat (8) @(posedge clk_in);
      check("pinprof", 32'(settings.active_profile), 32'(exp_prof(1'b0, 2'h3, pins)));
    end
    // live state word: profile in use, external start level, synced pins
    rd(TGCR_IDX_STATUS, {11'h000, pins, 1'b0, pins});
    // profile-3 start and hold times hold full 16-bit values
    step_rnd();
    wr(TGCR_IDX_P3_START, rnd[15:0]);
    wr(TGCR_IDX_P3_HOLD, rnd[31:16]);
    repeat (2) @(posedge clk_in);
    check("p3start", 32'(settings.p3_start_time), 32'(rnd[15:0]));
    check("p3hold", 32'(settings.p3_hold_time), 32'(rnd[31:16]));
    rd(TGCR_IDX_P3_START, rnd[15:0]);
    rd(TGCR_IDX_P3_HOLD, rnd[31:16]);
    // low lane only: the upper byte keeps its old value
    wstrb <= 4'h1;
    wr(TGCR_IDX_P3_START, ~rnd[15:0]);
    wstrb <= 4'h3;
    rd(TGCR_IDX_P3_START, {rnd[15:8], ~rnd[7:0]});
    // manual start: one pulse for a one, nothing for a zero
    wr(TGCR_IDX_MODE_CTRL, 16'h0000);
    repeat (4) @(posedge clk_in);
    p0 = 16'(pulses);
    wr(TGCR_IDX_MODE_CTRL, 16'h0400);
    repeat (5) @(posedge clk_in);
    check("oneshot", 32'(pulses - int'(p0)), 32'h0000_0001);
    wr(TGCR_IDX_MODE_CTRL, 16'h0000);
    repeat (5) @(posedge clk_in);
    check("noshot", 32'(pulses - int'(p0)), 32'h0000_0001);
    // external start: one pulse per rising edge, none while held high
    ext_start <= 1'b1;
    repeat (16) @(posedge clk_in);
    check("extstart", 32'(pulses - int'(p0)), 32'h0000_0002);
    ext_start <= 1'b0;
    // internal periodic start with external edges ignored meanwhile
    step_rnd();
    wt = 16'(rnd[3:0]) + 16'h0004;
    wr(TGCR_IDX_WAIT, wt);
    rd(TGCR_IDX_WAIT, wt);
    wr(TGCR_IDX_MODE_CTRL, 16'h4000);
    repeat (3 * (int'(wt) + 1)) @(posedge clk_in);
    pmin = 1000;
    ext_start <= 1'b1;
    repeat (4 * (int'(wt) + 1)) @(posedge clk_in);
    check("period", 32'(pmin), 32'(wt) + 32'h0000_0001);
    ext_start <= 1'b0;
    wr(TGCR_IDX_MODE_CTRL, 16'h0000);
    // unmapped address aliasing mode control: refused, no effect
    axi_write(32'h0001_02d4, 16'h3000, TGCR_RESP_SLVERR);
    axi_read(32'h0001_02d4, 32'h0000_0000, TGCR_RESP_SLVERR);
    rd(TGCR_IDX_MODE_CTRL, 16'h0000);
    complete_run();
  end
endmodule
